// ===== core/rsc_pkg.sv
// Package: register map, field positions, cause codes and timing of the reset source controller
package rsc_pkg;
	localparam logic [7:0] RSC_REG_ADDR = 8'hef;
	localparam int RSC_BIT_PIN = 0;
	localparam int RSC_BIT_POWER = 1;
	localparam int RSC_BIT_MISSCLK = 2;
	localparam int RSC_BIT_WDOG = 3;
	localparam int RSC_BIT_SOFT = 4;
	localparam int RSC_BIT_COMP = 5;
	localparam int RSC_BIT_FLASH = 6;
	localparam int RSC_BIT_USB = 7;
	localparam logic [7:0] RSC_REG_RESET = 8'h02;
	localparam logic [7:0] RSC_ENABLE_RESET = 8'h00;
	localparam int RSC_WDOG_DIV = 12;
	localparam int RSC_WDOG_DIV_W = 4;
	localparam int RSC_CLK_MHZ = 100;
	localparam int RSC_MCD_TIMEOUT_NS = 1000;
	localparam int RSC_MCD_CYCLES = (RSC_MCD_TIMEOUT_NS * RSC_CLK_MHZ) / 1000;
	localparam int RSC_HOLD_CYCLES = 4;
	localparam int RSC_WDOG_W = 16;

	typedef enum logic [2:0] {
		RSC_ST_POWERUP,
		RSC_ST_HOLD,
		RSC_ST_RUN
	} rsc_state_e;

	// Special function register access from the processor
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rsc_sfr_req_s;

	// Flash error conditions, one line per cause
	typedef struct packed {
		logic prog_above_user;
		logic const_read_above_user;
		logic branch_above_user;
		logic security_block;
		logic write_without_monitor;
	} rsc_flash_err_s;

	// Asynchronous reset sources from the analog side and pins
	typedef struct packed {
		logic pin_rst_n;
		logic comp_noninv_low;
		logic supply_low;
		logic monitor_enabled;
		logic monitor_stable;
		logic vbus_level;
	} rsc_async_s;
endpackage

// ===== core/rsc_watchdog_div.sv
// Divide-by-twelve watchdog count enable and overflow tracker
`timescale 1ns/1ps
module rsc_watchdog_div #(
	parameter int WIDTH = rsc_pkg::RSC_WDOG_W
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic enable_in,
	input wire logic service_in,
	input wire logic [WIDTH-1:0] limit_in,
	output logic tick_out,
	output logic overflow_out
);
	import rsc_pkg::*;

	logic [RSC_WDOG_DIV_W-1:0] div_q;
	logic [WIDTH-1:0] count_q;
	logic div_wrap;

	initial begin
		if (WIDTH < 2) $error("rsc_watchdog_div: WIDTH too small");
	end

	assign div_wrap = (div_q == RSC_WDOG_DIV_W'(RSC_WDOG_DIV - 1));

	// System clock divided by twelve
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			div_q <= '0;
			tick_out <= 1'b0;
		end else begin
			div_q <= div_wrap ? '0 : div_q + 1'b1;
			tick_out <= div_wrap;
		end
	end

	// Count ticks until serviced; overflow is a one-cycle pulse
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || service_in || !enable_in) begin
			count_q <= '0;
			overflow_out <= 1'b0;
		end else if (tick_out) begin
			count_q <= (count_q == limit_in) ? '0 : count_q + 1'b1;
			overflow_out <= (count_q == limit_in);
		end else begin
			overflow_out <= 1'b0;
		end
	end
endmodule

// ===== core/rsc_reset_ctrl.sv
// Reset source controller: combines reset sources, holds enables and cause flags
//
// Notes on behaviour
// - Watchdog comes up enabled after every reset, counting at system clock over 12.
// - Unserviced watchdog overflow resets the system; bit 3 then reads 1.
// - Flash access above user space by programmer, constant read or branch resets.
// - Security-blocked flash access or write without supply monitor also resets.
// - After a flash-error reset, read-only bit 6 reads 1.
// - Writing 1 to bit 4 forces reset; bit 4 then reads 1.
// - Bit 7 enables USB source; bus reset or VBUS edge then resets.
// - After a USB-caused reset, bit 7 reads 1.
// - Internal resets never drive the external reset pin.
// - Bit 5 enables comparator reset; reads 1 when comparator caused reset.
// - Bit 2 enables missing-clock detector; reads 1 after its timeout reset.
// - Bit 1 enables supply-monitor source; reads 1 after power-on or monitor reset.
// - Enabling monitor source before monitor is stable causes immediate reset.
// - Bit 0 reads 1 when the external pin caused the last reset.
// - Register decoded at address 0xef on every register page.
// - Low pin level holds reset; pin flag set when that reset ends.
// - Enabled detector resets if system clock stalls longer than timeout.
// - Enabled comparator holds reset while noninverting input is below inverting.
`timescale 1ns/1ps
module rsc_reset_ctrl #(
	parameter int MCD_CYCLES = rsc_pkg::RSC_MCD_CYCLES,
	parameter int HOLD_CYCLES = rsc_pkg::RSC_HOLD_CYCLES,
	parameter int WDOG_W = rsc_pkg::RSC_WDOG_W
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input rsc_pkg::rsc_sfr_req_s sfr_in,
	input rsc_pkg::rsc_flash_err_s flash_err_in,
	input rsc_pkg::rsc_async_s async_in,
	input wire logic clk_stall_in,
	input wire logic usb_enabled_in,
	input wire logic usb_bus_reset_in,
	input wire logic wdog_service_in,
	input wire logic wdog_disable_in,
	input wire logic [WDOG_W-1:0] wdog_limit_in,
	output logic [7:0] sfr_rdata_out,
	output logic sys_rst_out,
	output logic wdog_enabled_out,
	output logic wdog_tick_out,
	output logic pin_rst_oe_out
);
	import rsc_pkg::*;

	// Idle levels for the synchroniser, so no source looks active just after reset
	localparam rsc_async_s SYNC_IDLE = '{pin_rst_n: 1'b1, comp_noninv_low: 1'b0, supply_low: 1'b0,
		monitor_enabled: 1'b1, monitor_stable: 1'b1, vbus_level: 1'b0};

	rsc_state_e state_q, state_d;
	rsc_async_s sync1_q, sync2_q;
	logic [7:0] enable_q, enable_d;
	logic [7:0] cause_q, cause_d;
	logic [7:0] pend_q, pend_d;
	logic [7:0] hold_cnt_q;
	logic [15:0] stall_cnt_q;
	logic vbus_prev_q;
	logic wdog_off_q;
	logic wdog_tick;
	logic wdog_ovf;
	logic in_reset;
	logic reg_hit;
	logic reg_wr;
	logic [7:0] trig;
	logic [7:0] reg_read;
	logic hold_done;
	logic any_trig;
	logic flash_fault;
	logic vbus_edge;
	logic stall_timeout;

	initial begin
		if (MCD_CYCLES < 1 || MCD_CYCLES > 65535) $error("rsc_reset_ctrl: MCD_CYCLES out of range");
		if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255) $error("rsc_reset_ctrl: HOLD_CYCLES out of range");
	end

	// Two-stage synchroniser for pin and analog inputs
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync1_q <= SYNC_IDLE;
			sync2_q <= SYNC_IDLE;
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	// Register decode, same on every page
	assign reg_hit = (sfr_in.addr == RSC_REG_ADDR);
	assign reg_wr = sfr_in.wr && reg_hit && !in_reset;
	assign in_reset = (state_q != RSC_ST_RUN);

	// Flash error causes
	assign flash_fault = flash_err_in.prog_above_user || flash_err_in.const_read_above_user
		|| flash_err_in.branch_above_user
		|| flash_err_in.security_block || flash_err_in.write_without_monitor;

	assign vbus_edge = sync2_q.vbus_level ^ vbus_prev_q;
	assign stall_timeout = (stall_cnt_q == 16'(MCD_CYCLES));

	// Per-source trigger vector in register bit order
	assign trig[RSC_BIT_PIN] = !sync2_q.pin_rst_n;
	assign trig[RSC_BIT_POWER] = enable_q[RSC_BIT_POWER]
		&& (sync2_q.supply_low || !sync2_q.monitor_enabled || !sync2_q.monitor_stable);
	assign trig[RSC_BIT_MISSCLK] = enable_q[RSC_BIT_MISSCLK] && stall_timeout;
	assign trig[RSC_BIT_WDOG] = wdog_ovf;
	assign trig[RSC_BIT_SOFT] = reg_wr && sfr_in.wdata[RSC_BIT_SOFT];
	assign trig[RSC_BIT_COMP] = enable_q[RSC_BIT_COMP] && sync2_q.comp_noninv_low;
	assign trig[RSC_BIT_FLASH] = flash_fault;
	assign trig[RSC_BIT_USB] = enable_q[RSC_BIT_USB]
		&& ((usb_enabled_in && usb_bus_reset_in) || vbus_edge);
	assign any_trig = |trig;
	assign hold_done = (hold_cnt_q == 8'(HOLD_CYCLES));

	// Sequencer: power-up, hold while any source active, then run
	always_comb begin
		state_d = state_q;
		pend_d = pend_q;
		cause_d = cause_q;
		enable_d = enable_q;
		case (state_q)
			RSC_ST_POWERUP: begin
				pend_d = 8'h00;
				if (hold_done) begin
					state_d = RSC_ST_RUN;
					cause_d = RSC_REG_RESET;
					enable_d = RSC_ENABLE_RESET;
				end
			end
			RSC_ST_HOLD: begin
				pend_d = pend_q | trig;
				if (hold_done && !any_trig) begin
					state_d = RSC_ST_RUN;
					// Lowest-numbered pending source wins, but a pending supply-monitor source beats the pin, so one flag reads 1
					cause_d = pend_q & (~pend_q + 8'h01);
					if (pend_q[RSC_BIT_POWER]) cause_d = RSC_REG_RESET;
					enable_d = RSC_ENABLE_RESET;
				end
			end
			default: begin
				if (any_trig) begin
					state_d = RSC_ST_HOLD;
					pend_d = trig;
				end else if (reg_wr) begin
					// Writable enables only; read-only flags ignored
					enable_d[RSC_BIT_USB] = sfr_in.wdata[RSC_BIT_USB];
					enable_d[RSC_BIT_COMP] = sfr_in.wdata[RSC_BIT_COMP];
					enable_d[RSC_BIT_MISSCLK] = sfr_in.wdata[RSC_BIT_MISSCLK];
					enable_d[RSC_BIT_POWER] = sfr_in.wdata[RSC_BIT_POWER];
				end
			end
		endcase
	end

	// Read value: cause flags ORed with the enables written since reset
	assign reg_read = cause_q | enable_q;

	// Sequencer state, flags and enables
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= RSC_ST_POWERUP;
			pend_q <= 8'h00;
			cause_q <= RSC_REG_RESET;
			enable_q <= RSC_ENABLE_RESET;
		end else begin
			state_q <= state_d;
			pend_q <= pend_d;
			cause_q <= cause_d;
			enable_q <= enable_d;
		end
	end

	// Reset hold counter restarts whenever a source is active during hold, and stays clear in run
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hold_cnt_q <= 8'h00;
		end else if (state_q == RSC_ST_RUN || (state_q == RSC_ST_HOLD && any_trig)) begin
			hold_cnt_q <= 8'h00;
		end else if (!hold_done) begin
			hold_cnt_q <= hold_cnt_q + 8'h01;
		end
	end

	// Missing-clock counter on the stall indication
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stall_cnt_q <= 16'h0000;
		end else if (!clk_stall_in || !enable_q[RSC_BIT_MISSCLK]) begin
			stall_cnt_q <= 16'h0000;
		end else if (!stall_timeout) begin
			stall_cnt_q <= stall_cnt_q + 16'h0001;
		end
	end

	// VBUS history and watchdog enable; watchdog re-enabled by every reset
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			vbus_prev_q <= 1'b0;
			wdog_off_q <= 1'b0;
		end else begin
			vbus_prev_q <= sync2_q.vbus_level;
			wdog_off_q <= in_reset ? 1'b0 : (wdog_off_q | wdog_disable_in);
		end
	end

	// Registered outputs; pin output enable never set by internal resets
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sfr_rdata_out <= 8'h00;
			sys_rst_out <= 1'b1;
			wdog_enabled_out <= 1'b1;
			wdog_tick_out <= 1'b0;
			pin_rst_oe_out <= 1'b0;
		end else begin
			sfr_rdata_out <= (sfr_in.rd && reg_hit) ? reg_read : 8'h00;
			sys_rst_out <= (state_d != RSC_ST_RUN);
			wdog_enabled_out <= !wdog_off_q;
			wdog_tick_out <= wdog_tick;
			pin_rst_oe_out <= 1'b0;
		end
	end

	rsc_watchdog_div #(
		.WIDTH(WDOG_W)
	) u_wdog (
		.clk_in(clk_in),
		.sys_rst_in(in_reset),
		.enable_in(!wdog_off_q),
		.service_in(wdog_service_in),
		.limit_in(wdog_limit_in),
		.tick_out(wdog_tick),
		.overflow_out(wdog_ovf)
	);

	sequence s_soft_write;
		reg_wr && sfr_in.wdata[RSC_BIT_SOFT];
	endsequence

	chk_soft_reset_fire: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_soft_write |=> sys_rst_out) else $error("software force did not reset");
	chk_soft_flag_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_q == RSC_ST_HOLD && state_d == RSC_ST_RUN && pend_q == 8'h10) |=> cause_q == 8'h10)
		else $error("software flag not recorded");
	chk_wdog_reset_fire: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(wdog_ovf && !in_reset) |=> sys_rst_out) else $error("watchdog overflow ignored");
	chk_flash_reset_fire: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(flash_fault && !in_reset) |=> sys_rst_out) else $error("flash error ignored");
	chk_pin_never_driven: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!pin_rst_oe_out) else $error("reset pin driven");
	chk_wdog_after_reset: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(in_reset) |-> !wdog_off_q) else $error("watchdog not enabled after reset");
	chk_one_cause_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(in_reset) |=> $onehot(cause_q)) else $error("cause flags not one-hot");
	chk_comp_hold_reset: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(enable_q[RSC_BIT_COMP] && sync2_q.comp_noninv_low) |=> sys_rst_out [*2])
		else $error("comparator did not hold reset");
	chk_pin_hold_reset: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!sync2_q.pin_rst_n |=> sys_rst_out) else $error("pin low but not in reset");
	chk_reg_decode: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(sfr_in.rd && sfr_in.addr != RSC_REG_ADDR) |=> sfr_rdata_out == 8'h00)
		else $error("foreign address answered");

	// Steps of the sequencer: entry into hold, reset held, exit to run
	sequence s_hold_entry;
		state_q == RSC_ST_RUN && any_trig;
	endsequence

	sequence s_reset_held;
		sys_rst_out [*2];
	endsequence

	sequence s_hold_exit;
		state_q == RSC_ST_HOLD && state_d == RSC_ST_RUN;
	endsequence

	// Reset lasts at least two cycles once any source fires
	chk_reset_held: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_hold_entry |=> s_reset_held)
		else $error("system reset shorter than hold");
	// Cause flag recorded for the source that alone caused the reset
	chk_pin_cause_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(s_hold_exit ##0 (pend_q == 8'h01)) |=> cause_q == 8'h01)
		else $error("pin flag not recorded");
	chk_wdog_cause_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(s_hold_exit ##0 (pend_q == 8'h08)) |=> cause_q == 8'h08)
		else $error("watchdog flag not recorded");
	chk_flash_cause_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(s_hold_exit ##0 (pend_q == 8'h40)) |=> cause_q == 8'h40)
		else $error("flash flag not recorded");
	chk_usb_cause_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(s_hold_exit ##0 (pend_q == 8'h80)) |=> cause_q == 8'h80)
		else $error("usb flag not recorded");
	// Enables do not survive the reset that ends
	chk_enable_cleared: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(in_reset) |-> enable_q == RSC_ENABLE_RESET)
		else $error("enables kept across reset");
	// With nothing enabled and no fixed source active, run continues
	chk_gated_quiet: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_q == RSC_ST_RUN && enable_q == 8'h00 && sync2_q.pin_rst_n && !flash_fault && !wdog_ovf
		&& !(reg_wr && sfr_in.wdata[RSC_BIT_SOFT])) |=> !sys_rst_out)
		else $error("disabled source caused reset");
	// Enabled sources reach the system reset
	chk_usb_reset_fire: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(enable_q[RSC_BIT_USB] && usb_enabled_in && usb_bus_reset_in && !in_reset) |=> sys_rst_out)
		else $error("usb bus reset ignored");
	chk_mcd_reset_fire: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(enable_q[RSC_BIT_MISSCLK] && stall_timeout && !in_reset) |=> sys_rst_out)
		else $error("missing clock ignored");
	// Watchdog count clock never ticks twice within nine cycles
	chk_tick_spacing: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wdog_tick |=> !wdog_tick [*8])
		else $error("watchdog tick too frequent");
endmodule

// ===== tb/rsc_src_model.sv
// Behavioural model of the on-chip reset sources and the reset pin
`timescale 1ns/1ps
module rsc_src_model (
	input wire logic [3:0] code_in,
	input wire logic on_in,
	output rsc_pkg::rsc_flash_err_s flash_out,
	output rsc_pkg::rsc_async_s async_out,
	output logic stall_out,
	output logic usb_en_out,
	output logic usb_bus_rst_out
);
	import rsc_pkg::*;
	wire logic hit_flash;
	// One source active per code from 0 to 11 while on_in is high
	assign hit_flash = on_in && code_in >= 4'h1 && code_in <= 4'h5;
	assign flash_out = hit_flash ? rsc_flash_err_s'(5'h10 >> (code_in - 4'h1)) : '0;
	assign async_out.pin_rst_n = !(on_in && code_in == 4'h0);
	assign usb_en_out = on_in && code_in == 4'h6;
	assign usb_bus_rst_out = on_in && code_in == 4'h6;
	assign async_out.vbus_level = on_in && code_in == 4'h7;
	assign async_out.comp_noninv_low = on_in && code_in == 4'h8;
	assign stall_out = on_in && code_in == 4'h9;
	assign async_out.supply_low = on_in && code_in == 4'ha;
	// Monitor switched off or not yet settled
	assign async_out.monitor_enabled = !(on_in && code_in == 4'hb);
	assign async_out.monitor_stable = !(on_in && code_in == 4'hb);
endmodule

// ===== tb/testbench.sv
// Self-checking testbench for the reset source controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
	import rsc_pkg::*;
	logic clk_in = 0, rstn_in = 0, src_on = 0, wd_svc = 0, wd_dis = 0;
	logic [3:0] code = 0;
	logic [15:0] limit = 16'hffff;
	rsc_sfr_req_s sfr = '0;
	rsc_flash_err_s ferr;
	rsc_async_s asy;
	logic stall, usb_en, usb_br, sys_rst, wd_en, wd_tick, oe;
	logic [7:0] rdata, rd_got, ra;
	int err_total = 0, n_compared = 0, i, n;

	rsc_src_model i_src (.code_in(code), .on_in(src_on), .flash_out(ferr), .async_out(asy),
		.stall_out(stall), .usb_en_out(usb_en), .usb_bus_rst_out(usb_br));
	rsc_reset_ctrl #(.MCD_CYCLES(4), .HOLD_CYCLES(4)) i_dut (.clk_in(clk_in), .rstn_in(rstn_in),
		.sfr_in(sfr), .flash_err_in(ferr), .async_in(asy), .clk_stall_in(stall), .usb_enabled_in(usb_en),
		.usb_bus_reset_in(usb_br), .wdog_service_in(wd_svc), .wdog_disable_in(wd_dis),
		.wdog_limit_in(limit), .sfr_rdata_out(rdata), .sys_rst_out(sys_rst), .wdog_enabled_out(wd_en),
		.wdog_tick_out(wd_tick), .pin_rst_oe_out(oe));

	// Free-running system clock
	initial begin
		forever #5 clk_in = ~clk_in;
	end

	task automatic give_verdict();
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic tick(int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask

	// One register access; read data captured in the cycle after rd
	task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
		sfr = '{wr: w, rd: !w, addr: a, wdata: d}; // Whole value only, never read-modify-write
		tick(1);
		rd_got = rdata;
		sfr = '0;
		tick(1);
	endtask

	task automatic wait_sys(logic lvl);
		int k;
		for (k = 0; k < 400 && sys_rst !== lvl; k++) tick(1);
		if (k == 400) begin
			err_total++;
			give_verdict();
		end
	endtask

	// Expected cause bit for each source code
	function automatic logic [7:0] bit_of(int c);
		int b;
		b = (c == 0) ? RSC_BIT_PIN : (c < 6) ? RSC_BIT_FLASH : (c < 8) ? RSC_BIT_USB : (c == 8) ? RSC_BIT_COMP
			: (c == 9) ? RSC_BIT_MISSCLK : (c < 12) ? RSC_BIT_POWER : (c == 12) ? RSC_BIT_SOFT : RSC_BIT_WDOG;
		return 8'h01 << b;
	endfunction

	function automatic logic [7:0] en_of(int c);
		return (c >= 6 && c <= 12) ? bit_of(c) : 8'h00;
	endfunction

	// Trigger one source, ride out the reset, read the cause back
	task automatic run_case(int c);
		code = c[3:0];
		src_on = (c < 12);
		if (c == 13) limit = 16'h0002;
		if (en_of(c) != 8'h00) bus(1'b1, RSC_REG_ADDR, en_of(c));
		wait_sys(1'b1);
		src_on = 0;
		limit = 16'hffff;
		wait_sys(1'b0);
		bus(1'b0, RSC_REG_ADDR, 8'h00);
		`CHK("pin_oe", 1'b0, oe)
		`CHK("wdog_on", 1'b1, wd_en)
	endtask

	initial begin
		void'($urandom(62));
		tick(5);
		rstn_in = 1;
		wait_sys(1'b0);
		bus(1'b0, RSC_REG_ADDR, 8'h00);
		`CHK("por_value", RSC_REG_RESET, rd_got)
		`CHK("wdog_on", 1'b1, wd_en)
		// Watchdog tick spacing
		for (i = 0; i < 30 && wd_tick !== 1'b1; i++) tick(1);
		if (i == 30) begin
			err_total++;
			give_verdict();
		end
		n = 0;
		do begin tick(1); n++; end while (wd_tick !== 1'b1 && n < 30);
		`CHK("tick_gap", RSC_WDOG_DIV, n)
		// Serviced watchdog stays quiet, then disabled one too
		limit = 16'h0002;
		repeat (10) begin
			wd_svc = 1;
			tick(1);
			wd_svc = 0;
			tick(9);
		end
		`CHK("serviced", 1'b0, sys_rst)
		wd_dis = 1;
		tick(1);
		wd_dis = 0;
		tick(60);
		`CHK("disabled", 1'b0, sys_rst)
		`CHK("wdog_off", 1'b0, wd_en)
		limit = 16'hffff;
		// Every source once, then random ones
		for (i = 0; i < 24; i++) begin
			n = (i < 14) ? i : $urandom % 14;
			run_case(n);
			`CHK("cause", bit_of(n), rd_got)
			ra = $urandom;
			if (ra == RSC_REG_ADDR) ra = ra ^ 8'h01;
			bus(1'b1, ra, 8'($urandom));
			bus(1'b0, ra, 8'h00);
			`CHK("other_addr", 8'h00, rd_got)
			bus(1'b0, RSC_REG_ADDR, 8'h00);
			`CHK("cause_kept", bit_of(n), rd_got)
		end
		// Gated sources stay silent while not enabled
		for (i = 6; i <= 10; i++) begin
			code = i[3:0];
			src_on = 1;
			tick(30);
			`CHK("gated", 1'b0, sys_rst)
			src_on = 0;
			tick(5);
		end
		give_verdict();
	end
endmodule
